// *** sim/tcp_channel_sva.sv ***
// Register port handshake and reset checks for the timer channel
`timescale 1ns/100ps
module tcp_channel_sva (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register port
	input wire logic [11:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Pins
	input wire logic        output_pin_a,
	input wire logic        output_pin_b,
	input wire logic        event_flag
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wr_bad;
		wr_taken ##0 (s_axi_awaddr > 12'h030);
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	b_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
		else $error("write answer missing");
	b_error_a: assert property (
		wr_bad |-> ##[1:3] (s_axi_bvalid && s_axi_bresp == 2'h2))
		else $error("unmapped write not refused");
	b_refuse_a: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during answer");
	b_clear_a: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	r_answer_a: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read answer missing");
	r_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted during answer");
	r_clear_a: assert property (
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	reset_quiet_a: assert property ($rose(aresetn) |->
		!output_pin_a && !output_pin_b && !event_flag)
		else $error("pins active out of reset");
endmodule

// *** sim/tcp_channel_tb_top.sv ***
// Self-checking bench for the timer capture and PWM channel
`timescale 1ns/100ps
`include "tcp_consts.svh"
module tcp_channel_tb_top;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        arvalid = 1'b0;
	logic        bready = 1'b1;
	logic        rready = 1'b1;
	logic [7:0]  csa = 8'h00;
	logic [7:0]  csb = 8'h00;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, v, f, m;
	logic        trig, pin_a, pin_b, evt;
	logic [1:0]  exp_b [$];
	logic [31:0] exp_d [$];
	logic [31:0] exp_m [$];
	logic [7:0]  md_tab [4] = '{8'h00, 8'h40, 8'h10, 8'h10};
	logic [15:0] r1_tab [4] = '{16'h0000, 16'h0000, 16'h0005, 16'h0003};
	logic [15:0] f1_tab [4] = '{16'h0000, 16'h0000, 16'h0005, 16'h0014};
	int          hi_tab [4] = '{4, 6, 0, 10};
	int          num_errors = 0;
	int          cmp_count = 0;
	int          hi;

	always #4 aclk = ~aclk;

	tcp_channel DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.external_trigger_in0(trig), .combine_src_a(csa),
		.combine_src_b(csb), .output_pin_a(pin_a), .output_pin_b(pin_b),
		.event_flag(evt));
	tcp_far_model far (.aclk(aclk), .pin_a(pin_a), .trig(trig));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r);
		exp_b.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] mk, output logic [31:0] d);
		exp_d.push_back(e);
		exp_m.push_back(mk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
	endtask

	// Answers are matched against the oldest noted expectation
	always @(posedge aclk) begin
		if (bvalid === 1'b1 && bready)
			chk({30'h0, bresp}, {30'h0, exp_b.pop_front()});
		if (rvalid === 1'b1 && rready) begin
			m = exp_m.pop_front();
			chk(rdata & m, exp_d.pop_front() & m);
		end
	end

	task automatic complete_run;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// About 600 cycles expected; generous margin
	initial begin
		#100000;
		num_errors++;
		complete_run;
	end

	initial begin
		void'($urandom(54292));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`TCP_OFF_PERIOD, 32'h0000_FFFF, 32'hFFFF_FFFF, v);
		rd(`TCP_OFF_MODE, 32'h0000_0000, 32'hFFFF_FFFF, v);
		f = $urandom & 32'h0000_FFFF;
		wr(`TCP_OFF_R0, f, `TCP_RESP_OKAY);
		rd(`TCP_OFF_R0, f, 32'hFFFF_FFFF, v);
		wr(12'h040, 32'h0000_0000, `TCP_RESP_SLVERR);
		wr(`TCP_OFF_MODE, 32'h0000_0001, `TCP_RESP_OKAY);
		// Continuous capture: stop-clears-counter alone restarts the count
		wr(`TCP_OFF_TRIG, 32'h0000_00D0, `TCP_RESP_OKAY);
		wr(`TCP_OFF_INTEN, 32'h0000_0001, `TCP_RESP_OKAY);
		wr(`TCP_OFF_CTRL, 32'h0000_0004, `TCP_RESP_OKAY);
		far.burst(20, 30);
		repeat (10) @(posedge aclk);
		rd(`TCP_OFF_F0, 32'h0000_0000, 32'h0000_0000, f);
		rd(`TCP_OFF_R0, 32'h0000_0000, 32'h0000_0000, v);
		chk((v - f) & 32'h0000_FFFF, 32'h0000_001E);
		chk({31'h0, evt}, 32'h0000_0001);
		wr(`TCP_OFF_INTST, 32'h0000_0001, `TCP_RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk({31'h0, evt}, 32'h0000_0000);
		rd(`TCP_OFF_STAT, 32'h0000_0001, 32'h0000_0001, v);
		wr(`TCP_OFF_CTRL, 32'h0000_0002, `TCP_RESP_OKAY);
		far.rest();
		// Single capture: trigger stop halts the count and flags it
		wr(`TCP_OFF_TRIG, 32'h0000_00B0, `TCP_RESP_OKAY);
		wr(`TCP_OFF_INTEN, 32'h0000_0002, `TCP_RESP_OKAY);
		wr(`TCP_OFF_COUNT, 32'h0000_0000, `TCP_RESP_OKAY);
		wr(`TCP_OFF_CTRL, 32'h0000_0004, `TCP_RESP_OKAY);
		far.burst(8, 12);
		repeat (10) @(posedge aclk);
		rd(`TCP_OFF_STAT, 32'h0000_0000, 32'h0000_0001, v);
		rd(`TCP_OFF_F0, 32'h0000_0000, 32'h0000_0000, f);
		rd(`TCP_OFF_R0, 32'h0000_0000, 32'h0000_0000, v);
		chk((v - f) & 32'h0000_FFFF, 32'h0000_000C);
		chk({31'h0, evt}, 32'h0000_0001);
		wr(`TCP_OFF_CTRL, 32'h0000_0002, `TCP_RESP_OKAY);
		far.rest();
		wr(`TCP_OFF_COUNT, 32'h0000_0000, `TCP_RESP_OKAY);
		wr(`TCP_OFF_MODE, 32'h0000_0000, `TCP_RESP_OKAY);
		wr(`TCP_OFF_PERIOD, 32'h0000_0009, `TCP_RESP_OKAY);
		wr(`TCP_OFF_R0, 32'h0000_0002, `TCP_RESP_OKAY);
		wr(`TCP_OFF_F0, 32'h0000_0006, `TCP_RESP_OKAY);
		wr(`TCP_OFF_CTRL, 32'h0000_0001, `TCP_RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			wr(`TCP_OFF_MODE, {24'h0, md_tab[i]}, `TCP_RESP_OKAY);
			wr(`TCP_OFF_R1, {16'h0, r1_tab[i]}, `TCP_RESP_OKAY);
			wr(`TCP_OFF_F1, {16'h0, f1_tab[i]}, `TCP_RESP_OKAY);
			far.meter(30, hi);
			far.meter(10, hi);
			chk(32'(hi), 32'(hi_tab[i]));
		end
		// Forced level holds the pin low, then the count takes over
		wr(`TCP_OFF_CTRL, 32'h0000_0008, `TCP_RESP_OKAY);
		far.meter(5, hi);
		far.meter(10, hi);
		chk(32'(hi), 32'h0000_0000);
		wr(`TCP_OFF_CTRL, 32'h0000_0000, `TCP_RESP_OKAY);
		far.meter(15, hi);
		far.meter(10, hi);
		chk(32'(hi), 32'h0000_000A);
		wr(`TCP_OFF_OCON, 32'h0000_0001, `TCP_RESP_OKAY);
		csa <= 8'($urandom) & 8'hFE;
		csb <= 8'($urandom);
		far.meter(5, hi);
		far.meter(10, hi);
		chk(32'(hi), 32'h0000_0000);
		csa <= csa | 8'h01;
		far.meter(5, hi);
		far.meter(10, hi);
		chk(32'(hi), 32'h0000_000A);
		wr(`TCP_OFF_CTRL, 32'h0000_0002, `TCP_RESP_OKAY);
		wr(`TCP_OFF_MODE, 32'h0000_0002, `TCP_RESP_OKAY);
		wr(`TCP_OFF_COUNT, 32'h0000_0000, `TCP_RESP_OKAY);
		wr(`TCP_OFF_CTRL, 32'h0000_0001, `TCP_RESP_OKAY);
		repeat (30) @(posedge aclk);
		rd(`TCP_OFF_STAT, 32'h0000_0000, 32'h0000_0001, v);
		chk({31'h0, pin_a}, 32'h0000_0000);
		wr(`TCP_OFF_MODE, 32'h0000_0006, `TCP_RESP_OKAY);
		repeat (4) @(posedge aclk);
		chk({31'h0, pin_a}, 32'h0000_0001);
		chk({31'h0, pin_b}, 32'h0000_0000);
		wr(`TCP_OFF_MODE, 32'h0000_0026, `TCP_RESP_OKAY);
		repeat (4) @(posedge aclk);
		chk({31'h0, pin_b}, 32'h0000_0001);
		wr(`TCP_OFF_MODE, 32'h0000_00A6, `TCP_RESP_OKAY);
		repeat (4) @(posedge aclk);
		chk({31'h0, pin_b}, 32'h0000_0000);
		complete_run;
	end
endmodule

bind tcp_channel tcp_channel_sva u_sva (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.output_pin_a(output_pin_a), .output_pin_b(output_pin_b),
	.event_flag(event_flag));

// *** sim/tcp_far_model.sv ***
// Far side: trigger pin source and pin A duty meter
`timescale 1ns/100ps
module tcp_far_model (
	// Clock
	input  wire logic aclk,
	// Pins
	input  wire logic pin_a,
	output logic      trig
);
	initial trig = 1'b0;
	// Rise, high span, fall, low span, rise; pin left high
	task automatic burst(input int hi, input int lo);
		trig <= 1'b1;
		repeat (hi) @(posedge aclk);
		trig <= 1'b0;
		repeat (lo) @(posedge aclk);
		trig <= 1'b1;
	endtask
	task automatic rest();
		trig <= 1'b0;
	endtask
	task automatic meter(input int n, output int hi);
		hi = 0;
		repeat (n) begin
			@(posedge aclk);
			if (pin_a === 1'b1) hi++;
		end
	endtask
endmodule

// *** verilog/tcp_channel.sv ***
// Timer channel: capture and two-output PWM with AXI4-Lite registers
// Overview of operation
// (R1) Mode bit one selects capture, zero PWM
// (R2) Source code 0000 routes external trigger 0
// (R3) Edge mode 000: start and stop on rise
// (R4) Capture: falling edge latches count to fall
// (R5) Capture: rising edge latches count to rise
// (R6) Trigger stop on rise halts, flags stop
// (R7) Stop-clears-counter clears count, flags rise point
// (R8) Capture enable makes trigger source capture
// (R9) PWM repeats with period from period register
// (R10) Count equal rise value drives output high
// (R11) Count equal fall value drives output low
// (R12) Continuous: start at stop level, then repeat
// (R13) One-shot stops after a period, stop level
// (R14) Stop level zero: low, restart period low
// (R15) Stop level one: high, restart period high
// (R16) Forced level held until next boundary
// (R17) Cleared counter restarts from zero, outputs follow
// (R18) Phase select and invert per pin
// (R19) Pins optionally ANDed with mask sources
// (R20) Rise above period or equal: 0% duty
// (R21) Fall above period, rise within: 100% duty
// (R22) Period is period value plus one counts
// (R23) Overflow clears; one-shot stops, clears running
// (R24) Trigger start or stop lands two cycles later
// (R25) Sixteen-bit registers; captures hold until overwritten
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
`include "tcp_consts.svh"
module tcp_channel
	import tcp_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address and data
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Trigger pin and AND sources
	input  wire logic        external_trigger_in0,
	input  wire logic [7:0]  combine_src_a,
	input  wire logic [7:0]  combine_src_b,
	// Pins and event level
	output logic             output_pin_a,
	output logic             output_pin_b,
	output logic             event_flag
);

	tcp_state_t q_ff;
	tcp_state_t nxt_q;

	// Register slot known to the decoder
	function automatic logic addr_ok(input logic [11:0] a);
		addr_ok = (a == `TCP_OFF_MODE) || (a == `TCP_OFF_TRIG) ||
			(a == `TCP_OFF_INTEN) || (a == `TCP_OFF_CTRL) ||
			(a == `TCP_OFF_STAT) || (a == `TCP_OFF_COUNT) ||
			(a == `TCP_OFF_PERIOD) || (a == `TCP_OFF_R0) ||
			(a == `TCP_OFF_F0) || (a == `TCP_OFF_R1) ||
			(a == `TCP_OFF_F1) || (a == `TCP_OFF_OCON) ||
			(a == `TCP_OFF_INTST);
	endfunction

	// Waveform level for one output from its rise and fall values
	function automatic logic wave_next(input logic cur,
		input logic [15:0] cnt, input logic [15:0] per,
		input logic [15:0] rv, input logic [15:0] fv);
		if (rv > per || rv == fv) begin
			wave_next = 1'b0; // see (R20)
		end else if (fv > per) begin
			wave_next = 1'b1; // see (R21)
		end else if (cnt == rv) begin
			wave_next = 1'b1; // see (R10)
		end else if (cnt == fv) begin
			wave_next = 1'b0; // see (R11)
		end else begin
			wave_next = cur;
		end
	endfunction

	// AND with the selected sources, unselected bits pass as one
	function automatic logic combine(input logic v,
		input logic [7:0] mask, input logic [7:0] src);
		combine = v & (&(src | ~mask)); // see (R19)
	endfunction

	logic [15:0] wmask;
	logic        trig;
	logic        rise_e;
	logic        fall_e;
	logic        wr_go;
	logic        rd_go;
	logic        start_e;
	logic        stop_e;
	logic        boundary;
	logic        pa;
	logic        pb;
	logic [31:0] rd;

	always_comb begin
		nxt_q = q_ff;
		wmask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
		// Source select: only external trigger 0 is wired here
		trig = (q_ff.trig[`TCP_TG_SRC_HI:`TCP_TG_SRC_LO] == `TCP_SRC_EXT0)
			? q_ff.ext0_sync[1] : 1'b0; // see (R2)
		nxt_q.ext0_sync = {q_ff.ext0_sync[0], external_trigger_in0};
		nxt_q.ext0_prev = q_ff.ext0_sync[1];
		rise_e = trig & ~q_ff.ext0_prev & q_ff.armed;
		fall_e = ~trig & q_ff.ext0_prev & q_ff.armed;
		start_e = 1'b0;
		stop_e = 1'b0;
		boundary = 1'b0;

		// Edge mode 000: both start and stop respond to rising edges
		nxt_q.pend_start = {q_ff.pend_start[0], 1'b0};
		nxt_q.pend_stop = {q_ff.pend_stop[0], 1'b0};
		if (q_ff.trig[`TCP_TG_TRM_HI:`TCP_TG_TRM_LO] == `TCP_TRM_RISE
			&& rise_e) begin // see (R3)
			if (!q_ff.running && q_ff.trig[`TCP_TG_ST])
				nxt_q.pend_start[0] = 1'b1;
			else if (q_ff.running && (q_ff.trig[`TCP_TG_SP]
				|| q_ff.trig[`TCP_TG_SPC]))
				nxt_q.pend_stop[0] = 1'b1; // see (R6) (R7)
		end

		// Capture on trigger edges
		if (q_ff.mode[`TCP_MD_CAP] && q_ff.trig[`TCP_TG_CAPEN]) begin // see (R1) (R8)
			if (fall_e && q_ff.running)
				nxt_q.cap_fall = q_ff.count; // see (R4) (R25)
			if (rise_e && q_ff.running)
				nxt_q.cap_rise = q_ff.count; // see (R5)
		end

		// Counter
		if (q_ff.running) begin
			if (q_ff.count >= q_ff.period) begin
				nxt_q.count = `TCP_ZERO16; // see (R22) (R23)
				boundary = 1'b1;
				if (q_ff.mode[`TCP_MD_OST])
					nxt_q.running = 1'b0; // see (R13)
			end else begin
				nxt_q.count = q_ff.count + `TCP_ONE16; // see (R9)
			end
		end
		start_e = q_ff.pend_start[1]; // see (R24)
		stop_e = q_ff.pend_stop[1];
		if (start_e && !q_ff.fstop) begin
			nxt_q.running = 1'b1;
			nxt_q.hold0 = 1'b1;
			nxt_q.hold1 = 1'b1;
		end
		if (stop_e) begin
			if (q_ff.trig[`TCP_TG_SPC]) begin
				nxt_q.count = `TCP_ZERO16; // see (R7)
				nxt_q.hold0 = 1'b0; // see (R17)
				nxt_q.hold1 = 1'b0;
				nxt_q.intst[`TCP_IE_RISE0] = 1'b1;
			end else begin
				nxt_q.running = 1'b0; // see (R6)
				nxt_q.intst[`TCP_IE_TSTOP] = 1'b1;
			end
		end

		// PWM waveforms
		if (!q_ff.running || q_ff.mode[`TCP_MD_CAP]) begin
			nxt_q.wave0 = q_ff.mode[`TCP_MD_STPO0]; // see (R14) (R15)
			nxt_q.wave1 = q_ff.mode[`TCP_MD_STPO1];
		end else begin
			if (boundary) begin
				nxt_q.hold0 = 1'b0; // see (R12)
				nxt_q.hold1 = 1'b0;
				if (!q_ff.fstop)
					nxt_q.fhold = 1'b0; // see (R16)
			end
			if (q_ff.hold0 || q_ff.fhold)
				nxt_q.wave0 = q_ff.mode[`TCP_MD_STPO0];
			else
				nxt_q.wave0 = wave_next(q_ff.wave0, q_ff.count,
					q_ff.period, q_ff.r0, q_ff.f0);
			if (q_ff.hold1 || q_ff.fhold)
				nxt_q.wave1 = q_ff.mode[`TCP_MD_STPO1];
			else
				nxt_q.wave1 = wave_next(q_ff.wave1, q_ff.count,
					q_ff.period, q_ff.r1, q_ff.f1);
		end
		if (q_ff.fstop)
			nxt_q.fhold = 1'b1;

		// AXI write
		wr_go = 1'b0;
		if (s_axi_awvalid && q_ff.awready) begin
			nxt_q.awdone = 1'b1;
			nxt_q.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q_ff.wready) begin
			nxt_q.wdone = 1'b1;
			nxt_q.wdata = s_axi_wdata;
		end
		if (q_ff.awdone && q_ff.wdone) begin
			wr_go = 1'b1;
			nxt_q.awdone = 1'b0;
			nxt_q.wdone = 1'b0;
			nxt_q.bvalid = 1'b1;
			nxt_q.bresp = addr_ok(q_ff.awaddr) ? `TCP_RESP_OKAY
				: `TCP_RESP_SLVERR;
		end
		if (q_ff.bvalid && s_axi_bready)
			nxt_q.bvalid = 1'b0;
		if (wr_go) begin
			if (q_ff.awaddr == `TCP_OFF_MODE) begin
				nxt_q.mode = q_ff.wdata[7:0];
			end else if (q_ff.awaddr == `TCP_OFF_TRIG) begin
				nxt_q.trig = q_ff.wdata[10:0];
			end else if (q_ff.awaddr == `TCP_OFF_INTEN) begin
				nxt_q.inten = q_ff.wdata[1:0];
			end else if (q_ff.awaddr == `TCP_OFF_CTRL) begin
				if (q_ff.wdata[`TCP_CT_START] && !q_ff.fstop) begin
					nxt_q.running = 1'b1;
					nxt_q.hold0 = 1'b1;
					nxt_q.hold1 = 1'b1;
				end
				if (q_ff.wdata[`TCP_CT_STOP])
					nxt_q.running = 1'b0;
				nxt_q.armed = q_ff.wdata[`TCP_CT_ARM];
				nxt_q.fstop = q_ff.wdata[`TCP_CT_FSTOP];
			end else if (q_ff.awaddr == `TCP_OFF_COUNT) begin
				if (!q_ff.running) begin
					nxt_q.count = `TCP_ZERO16; // see (R17)
					nxt_q.hold0 = 1'b0;
					nxt_q.hold1 = 1'b0;
				end
			end else if (q_ff.awaddr == `TCP_OFF_PERIOD) begin
				if (q_ff.wdata[15:0] != `TCP_ZERO16)
					nxt_q.period = q_ff.wdata[15:0]; // see (R22)
			end else if (q_ff.awaddr == `TCP_OFF_R0) begin
				nxt_q.r0 = (q_ff.r0 & ~wmask) | (q_ff.wdata[15:0] & wmask);
			end else if (q_ff.awaddr == `TCP_OFF_F0) begin
				nxt_q.f0 = (q_ff.f0 & ~wmask) | (q_ff.wdata[15:0] & wmask);
			end else if (q_ff.awaddr == `TCP_OFF_R1) begin
				nxt_q.r1 = (q_ff.r1 & ~wmask) | (q_ff.wdata[15:0] & wmask);
			end else if (q_ff.awaddr == `TCP_OFF_F1) begin
				nxt_q.f1 = (q_ff.f1 & ~wmask) | (q_ff.wdata[15:0] & wmask);
			end else if (q_ff.awaddr == `TCP_OFF_OCON) begin
				nxt_q.ocon = q_ff.wdata[15:0];
			end else if (q_ff.awaddr == `TCP_OFF_INTST) begin
				// Write one to clear; a same-cycle event wins only if its bit was clear
				nxt_q.intst = (q_ff.intst & ~q_ff.wdata[1:0])
					| (nxt_q.intst & ~q_ff.intst);
			end
		end

		// AXI read
		rd = 32'h0000_0000;
		if (s_axi_araddr == `TCP_OFF_MODE) begin
			rd[7:0] = q_ff.mode;
		end else if (s_axi_araddr == `TCP_OFF_TRIG) begin
			rd[10:0] = q_ff.trig;
		end else if (s_axi_araddr == `TCP_OFF_INTEN) begin
			rd[1:0] = q_ff.inten;
		end else if (s_axi_araddr == `TCP_OFF_CTRL) begin
			rd[`TCP_CT_ARM] = q_ff.armed;
			rd[`TCP_CT_FSTOP] = q_ff.fstop;
		end else if (s_axi_araddr == `TCP_OFF_STAT) begin
			rd[0] = q_ff.running;
			rd[1] = q_ff.wave0;
			rd[2] = q_ff.wave1;
		end else if (s_axi_araddr == `TCP_OFF_COUNT) begin
			rd[15:0] = q_ff.count;
		end else if (s_axi_araddr == `TCP_OFF_PERIOD) begin
			rd[15:0] = q_ff.period;
		end else if (s_axi_araddr == `TCP_OFF_R0) begin
			rd[15:0] = q_ff.mode[`TCP_MD_CAP] ? q_ff.cap_rise : q_ff.r0;
		end else if (s_axi_araddr == `TCP_OFF_F0) begin
			rd[15:0] = q_ff.mode[`TCP_MD_CAP] ? q_ff.cap_fall : q_ff.f0;
		end else if (s_axi_araddr == `TCP_OFF_R1) begin
			rd[15:0] = q_ff.r1;
		end else if (s_axi_araddr == `TCP_OFF_F1) begin
			rd[15:0] = q_ff.f1;
		end else if (s_axi_araddr == `TCP_OFF_OCON) begin
			rd[15:0] = q_ff.ocon;
		end else if (s_axi_araddr == `TCP_OFF_INTST) begin
			rd[1:0] = q_ff.intst;
		end
		rd_go = s_axi_arvalid && q_ff.arready;
		if (rd_go) begin
			nxt_q.rvalid = 1'b1;
			nxt_q.rdata = rd;
			nxt_q.rresp = addr_ok(s_axi_araddr) ? `TCP_RESP_OKAY
				: `TCP_RESP_SLVERR;
		end else if (q_ff.rvalid && s_axi_rready) begin
			nxt_q.rvalid = 1'b0;
		end
		// Ready levels registered so every bus output comes from a flop
		nxt_q.awready = ~nxt_q.awdone & ~nxt_q.bvalid;
		nxt_q.wready = ~nxt_q.wdone & ~nxt_q.bvalid;
		nxt_q.arready = ~nxt_q.rvalid;

		// Pin phase, inversion and AND combination
		pa = q_ff.mode[`TCP_MD_OSL0] ? q_ff.wave1 : q_ff.wave0; // see (R18)
		pb = q_ff.mode[`TCP_MD_OSL1] ? q_ff.wave0 : q_ff.wave1;
		pa = combine(pa, q_ff.ocon[7:0], combine_src_a);
		pb = combine(pb, q_ff.ocon[15:8], combine_src_b);
		nxt_q.pin_a = pa ^ q_ff.mode[`TCP_MD_INVA];
		nxt_q.pin_b = pb ^ q_ff.mode[`TCP_MD_INVB];
		nxt_q.irq = |(q_ff.intst & q_ff.inten);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q_ff <= '0;
			q_ff.period <= `TCP_PERIOD_RST;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign s_axi_awready = q_ff.awready;
	assign s_axi_wready  = q_ff.wready;
	assign s_axi_bvalid  = q_ff.bvalid;
	assign s_axi_bresp   = q_ff.bresp;
	assign s_axi_arready = q_ff.arready;
	assign s_axi_rvalid  = q_ff.rvalid;
	assign s_axi_rdata   = q_ff.rdata;
	assign s_axi_rresp   = q_ff.rresp;
	assign output_pin_a  = q_ff.pin_a;
	assign output_pin_b  = q_ff.pin_b;
	assign event_flag    = q_ff.irq;

endmodule

// *** verilog/tcp_consts.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef TCP_CONSTS_SVH
`define TCP_CONSTS_SVH
`define TCP_OFF_MODE        12'h000
`define TCP_OFF_TRIG        12'h004
`define TCP_OFF_INTEN       12'h008
`define TCP_OFF_CTRL        12'h00C
`define TCP_OFF_STAT        12'h010
`define TCP_OFF_COUNT       12'h014
`define TCP_OFF_PERIOD      12'h018
`define TCP_OFF_R0          12'h01C
`define TCP_OFF_F0          12'h020
`define TCP_OFF_R1          12'h024
`define TCP_OFF_F1          12'h028
`define TCP_OFF_OCON        12'h02C
`define TCP_OFF_INTST       12'h030
// Mode register fields
`define TCP_MD_CAP          0
`define TCP_MD_OST          1
`define TCP_MD_STPO0        2
`define TCP_MD_STPO1        3
`define TCP_MD_OSL0         4
`define TCP_MD_OSL1         5
`define TCP_MD_INVA         6
`define TCP_MD_INVB         7
// Trigger control fields
`define TCP_TG_SRC_HI       3
`define TCP_TG_SRC_LO       0
`define TCP_TG_ST           4
`define TCP_TG_SP           5
`define TCP_TG_SPC          6
`define TCP_TG_CAPEN        7
`define TCP_TG_TRM_HI       10
`define TCP_TG_TRM_LO       8
`define TCP_SRC_EXT0        4'h0
`define TCP_TRM_RISE        3'h0
// Control register bits (start and stop act on write one; arm and forced stop are levels)
`define TCP_CT_START        0
`define TCP_CT_STOP         1
`define TCP_CT_ARM          2
`define TCP_CT_FSTOP        3
// Interrupt enable and status bits
`define TCP_IE_RISE0        0
`define TCP_IE_TSTOP        1
`define TCP_TRIG_DLY        2'h2
`define TCP_PERIOD_RST      16'hFFFF
`define TCP_ZERO16          16'h0000
`define TCP_ONE16           16'h0001
`define TCP_RESP_OKAY       2'h0
`define TCP_RESP_SLVERR     2'h2
`endif

// *** verilog/tcp_pkg.sv ***
// Types for the timer capture and PWM channel
package tcp_pkg;
	typedef struct packed {
		logic        awdone;
		logic        wdone;
		logic        awready;
		logic        wready;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic        arready;
		logic [7:0]  mode;
		logic [10:0] trig;
		logic [1:0]  inten;
		logic [1:0]  intst;
		logic [15:0] ocon;
		logic [15:0] count;
		logic [15:0] period;
		logic [15:0] r0;
		logic [15:0] f0;
		logic [15:0] r1;
		logic [15:0] f1;
		logic [15:0] cap_rise;
		logic [15:0] cap_fall;
		logic        running;
		logic        armed;
		logic        fstop;
		logic        fhold;
		logic        hold0;
		logic        hold1;
		logic        wave0;
		logic        wave1;
		logic [1:0]  ext0_sync;
		logic        ext0_prev;
		logic [1:0]  pend_start;
		logic [1:0]  pend_stop;
		logic        pin_a;
		logic        pin_b;
		logic        irq;
	} tcp_state_t;
endpackage
